// [design/char_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Synchronous FIFO with valid/ready on both sides
module char_fifo #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Fill level
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = count_q != (AW+1)'(DEPTH);
	assign out_valid = count_q != '0;
	assign out_data = mem[rd_ptr_q];
	assign level = count_q;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : char_fifo
`default_nettype wire

// [design/tape_tx.sv]
// Operation
// - Each character goes out as a serial frame spanning 7.00 unit intervals.
// - Unit timing is 75 or 45.5 baud, chosen by configuration, fixed while sending.
// - Keyboard-only mode keeps the transmitter off the line, except to finish a frame already under way.
// - Tape modes send only with send, tape present, run and no tight tape.
// - Only on-line sending of stored tape characters; no local-only function.
// - The local printer receives the outgoing line signal as a monitor.
// - All conditions met but run: stay idle; run starts the first cycle.
// - Keep sending tape characters in order until run is switched off.
// - Latch the five bits, then send start, five data, stop elements.
// - With enable held, next cycle starts right after the last, no gap.
// - Enable lost mid-cycle: finish the frame, halt at home, never truncate.
// - Input is a parallel five-unit code, read ahead into the FIFO_DEPTH character buffer, one character per tape_feed pulse.
// - The start element is always spacing.
// - Losing tape-present removes enable so no false all-marking character goes.
// - After a tight-tape stop, sending resumes by itself if run stays on.
`timescale 1ns/1ps
`default_nettype none
module tape_tx #(
	parameter int UNIT_CYC_FAST = tape_tx_pkg::UNIT_CYC_FAST,
	parameter int UNIT_CYC_SLOW = tape_tx_pkg::UNIT_CYC_SLOW,
	parameter int FIFO_DEPTH = tape_tx_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB slave
	input wire logic [tape_tx_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Operator switches and tape contacts
	input wire tape_tx_pkg::panel_t panel_in,
	// Tape reader
	input wire logic [tape_tx_pkg::CHAR_BITS-1:0] tape_data,
	output logic tape_feed,
	// Telegraph line and local monitor
	output logic line_mark,
	output logic line_drive_en,
	output logic monitor_mark
);
	localparam int CW = tape_tx_pkg::CNT_W;
	localparam int NB = tape_tx_pkg::CHAR_BITS;
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	typedef enum {
		TX_HOME,
		TX_SEND
	} tx_state_t;

	// ==========================================================
	// Pin synchronisers
	tape_tx_pkg::panel_t panel_s1_q;
	tape_tx_pkg::panel_t panel_q;
	logic [NB-1:0] data_s1_q;
	logic [NB-1:0] data_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			panel_s1_q <= '0;
			panel_q <= '0;
			data_s1_q <= '0;
			data_q <= '0;
		end else begin
			panel_s1_q <= panel_in;
			panel_q <= panel_s1_q;
			data_s1_q <= tape_data;
			data_q <= data_s1_q;
		end
	end

	// ==========================================================
	// Configuration and status registers
	tape_tx_pkg::apb_req_t req;
	tape_tx_pkg::mode_t mode_q;
	tape_tx_pkg::mode_t mode_d;
	logic rate_cfg_q;
	logic rate_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [NB-1:0] last_char_q;
	logic [31:0] char_count_q;

	assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

	wire access = req.psel && req.penable && !pready_q;
	wire commit = req.psel && req.penable && pready_q;
	wire hit_ctrl = req.paddr == tape_tx_pkg::CTRL_OFF;
	wire hit_status = req.paddr == tape_tx_pkg::STATUS_OFF;
	wire hit_char = req.paddr == tape_tx_pkg::CHAR_OFF;
	wire hit_count = req.paddr == tape_tx_pkg::COUNT_OFF;
	wire hit_any = hit_ctrl || hit_status || hit_char || hit_count;
	wire wr_ctrl = commit && req.pwrite && hit_ctrl;
	wire [1:0] mode_field = req.pwdata[tape_tx_pkg::CTRL_MODE_LSB +: 2];

	// Unused mode code falls back to keyboard-only
	assign mode_d = (mode_field == 2'(tape_tx_pkg::MODE_KEY_TAPE)) ? tape_tx_pkg::MODE_KEY_TAPE :
		(mode_field == 2'(tape_tx_pkg::MODE_TAPE)) ? tape_tx_pkg::MODE_TAPE : tape_tx_pkg::MODE_KEYBOARD;

	// ==========================================================
	// Transmit enable path
	wire tape_mode = mode_q != tape_tx_pkg::MODE_KEYBOARD;
	wire tx_enable = tape_mode && panel_q.send_req && panel_q.run
		&& panel_q.tape_present && !panel_q.tape_tight;

	// ==========================================================
	// Tape reader: sense, store, advance
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [NB-1:0] fifo_out_data;
	logic [LW-1:0] fifo_level;
	logic [3:0] settle_q;
	logic tape_feed_q;

	wire settled = settle_q == 4'h0;
	wire sense = tx_enable && settled && fifo_in_ready;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			settle_q <= 4'h0;
			tape_feed_q <= 1'b0;
		end else begin
			tape_feed_q <= sense;
			if (sense) begin
				settle_q <= 4'(tape_tx_pkg::FEED_SETTLE_CYC);
			end else if (!settled) begin
				settle_q <= settle_q - 4'h1;
			end
		end
	end

	// ==========================================================
	// Character buffer between reader and line
	logic fifo_pop;

	char_fifo #(
		.WIDTH(NB),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(ref_clk),
		.rst(rst),
		.in_valid(sense),
		.in_ready(fifo_in_ready),
		.in_data(data_q),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	// ==========================================================
	// Frame sequencer
	tx_state_t state_q;
	tx_state_t state_d;
	logic [2:0] elem_q;
	logic [CW-1:0] tick_q;
	logic [NB-1:0] shift_q;
	logic line_mark_q;
	logic line_en_q;

	wire [CW-1:0] unit_cyc = rate_q ? CW'(UNIT_CYC_SLOW) : CW'(UNIT_CYC_FAST);
	wire [CW-1:0] stop_cyc = CW'((64'(unit_cyc) * tape_tx_pkg::STOP_UNITS_X100) / tape_tx_pkg::ELEM_UNITS_X100);
	wire [CW-1:0] elem_len = (elem_q == tape_tx_pkg::ELEM_STOP) ? stop_cyc : unit_cyc;
	wire elem_done = tick_q == elem_len - CW'(1);
	wire frame_done = (state_q == TX_SEND) && elem_done && (elem_q == tape_tx_pkg::ELEM_STOP);
	wire at_home = (state_q == TX_HOME) || frame_done;
	wire start_frame = at_home && tx_enable && fifo_out_valid;

	assign fifo_pop = start_frame;
	assign state_d = start_frame ? TX_SEND : (frame_done ? TX_HOME : state_q);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= TX_HOME;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			elem_q <= tape_tx_pkg::ELEM_START;
			tick_q <= '0;
			shift_q <= '0;
		end else if (start_frame) begin
			elem_q <= tape_tx_pkg::ELEM_START;
			tick_q <= '0;
			shift_q <= fifo_out_data;
		end else if (state_q == TX_SEND) begin
			if (elem_done) begin
				tick_q <= '0;
				elem_q <= elem_q + 3'h1;
				if (elem_q != tape_tx_pkg::ELEM_START) begin
					shift_q <= shift_q >> 1;
				end
			end else begin
				tick_q <= tick_q + CW'(1);
			end
		end
	end

	// ==========================================================
	// Line level
	logic line_d;

	always_comb begin
		line_d = 1'b1;
		case (state_d)
			TX_HOME: line_d = 1'b1;
			TX_SEND: begin
				if (start_frame) begin
					line_d = 1'b0;
				end else if (elem_done && elem_q == tape_tx_pkg::ELEM_START) begin
					line_d = shift_q[0];
				end else if (elem_done && elem_q != tape_tx_pkg::ELEM_STOP) begin
					line_d = (elem_q == 3'(NB)) ? 1'b1 : shift_q[1];
				end else begin
					line_d = line_mark_q;
				end
			end
			default: line_d = 1'b1;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			line_mark_q <= 1'b1;
			line_en_q <= 1'b0;
		end else begin
			line_mark_q <= line_d;
			line_en_q <= tape_mode || (state_d == TX_SEND);
		end
	end

	// ==========================================================
	// APB slave logic
	wire busy = state_q == TX_SEND;
	wire [31:0] status_word = {{(32 - 12 - LW){1'b0}}, fifo_level, busy, elem_q,
		line_mark_q, line_en_q, tx_enable, rate_q, panel_q};
	wire [31:0] read_word = hit_ctrl ? {29'h0, rate_cfg_q, 2'(mode_q)} :
		hit_status ? status_word :
		hit_char ? {27'h0, last_char_q} :
		hit_count ? char_count_q : 32'h0000_0000;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= access;
			pslverr_q <= access && !hit_any;
			prdata_q <= (access && !req.pwrite) ? read_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_q <= tape_tx_pkg::MODE_KEYBOARD;
			rate_cfg_q <= tape_tx_pkg::CTRL_RATE_RST;
			rate_q <= tape_tx_pkg::CTRL_RATE_RST;
		end else begin
			if (wr_ctrl) begin
				mode_q <= mode_d;
				rate_cfg_q <= req.pwdata[tape_tx_pkg::CTRL_RATE_BIT];
			end
			if (at_home && !start_frame) begin
				rate_q <= rate_cfg_q;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			last_char_q <= '0;
			char_count_q <= 32'h0000_0000;
		end else if (start_frame) begin
			last_char_q <= fifo_out_data;
			char_count_q <= char_count_q + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign tape_feed = tape_feed_q;
	assign line_mark = line_mark_q;
	assign line_drive_en = line_en_q;
	assign monitor_mark = line_mark_q;
endmodule : tape_tx
`default_nettype wire

// [design/tape_tx_pkg.sv]
// ==========================================================
// Shared constants and types
package tape_tx_pkg;
	// ==========================================================
	// Clock and line timing
	localparam int CLK_HZ = 10_000_000;
	localparam int BAUD_FAST_X100 = 7500;
	localparam int BAUD_SLOW_X100 = 4550;
	// Longest element time rounds down
	localparam int UNIT_CYC_FAST = (CLK_HZ / BAUD_FAST_X100) * 100 + ((CLK_HZ % BAUD_FAST_X100) * 100) / BAUD_FAST_X100;
	localparam int UNIT_CYC_SLOW = (CLK_HZ / BAUD_SLOW_X100) * 100 + ((CLK_HZ % BAUD_SLOW_X100) * 100) / BAUD_SLOW_X100;
	localparam int FRAME_UNITS_X100 = 700;
	localparam int ELEM_UNITS_X100 = 100;
	localparam int CHAR_BITS = 5;
	localparam int STOP_UNITS_X100 = FRAME_UNITS_X100 - (CHAR_BITS + 1) * ELEM_UNITS_X100;
	localparam int CNT_W = 20;
	localparam int FEED_SETTLE_CYC = 4;
	localparam int FIFO_DEPTH = 16;

	// ==========================================================
	// Element indices inside a frame
	localparam logic [2:0] ELEM_START = 3'h0;
	localparam logic [2:0] ELEM_STOP = 3'h6;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 12;
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STATUS_OFF = 12'h004;
	localparam logic [11:0] CHAR_OFF = 12'h008;
	localparam logic [11:0] COUNT_OFF = 12'h00C;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_RATE_BIT = 2;
	localparam logic CTRL_RATE_RST = 1'b0;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		MODE_KEYBOARD,
		MODE_KEY_TAPE,
		MODE_TAPE
	} mode_t;

	typedef struct packed {
		logic send_req;
		logic run;
		logic tape_present;
		logic tape_tight;
	} panel_t;

	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_t;
endpackage : tape_tx_pkg

// [tb/line_rx.sv]
`timescale 1ns/1ps
`default_nettype none
// ======
// Telegraph line receiver, mid-element sampling
module line_rx (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Line
	input wire logic line_mark,
	input wire logic [7:0] unit,
	// Received traffic
	output logic [4:0] rx_char,
	output int rx_n,
	output int gap,
	output logic stop_bad
);
	int pos;
	int since;
	logic [4:0] sh;
	always @(posedge clk) begin
		since <= since + 1;
		if (rst) begin
			pos <= 0;
			since <= 0;
			rx_n <= 0;
			stop_bad <= 1'b0;
		end else if (pos == 0) begin
			if (!line_mark) begin
				pos <= 1;
				gap <= since;
				since <= 1;
			end
		end else begin
			pos <= (pos == 7 * unit - 1) ? 0 : pos + 1;
			if (pos % unit == unit / 2 && pos > unit && pos < 6 * unit)
				sh <= {line_mark, sh[4:1]};
			if (pos == 6 * unit + unit / 2) begin
				rx_char <= sh;
				rx_n <= rx_n + 1;
				stop_bad <= stop_bad | !line_mark;
			end
		end
	end
endmodule : line_rx
`default_nettype wire

// [tb/tape_tx_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module tape_tx_sva #(
	parameter int UNIT_CYC_FAST = tape_tx_pkg::UNIT_CYC_FAST,
	parameter int UNIT_CYC_SLOW = tape_tx_pkg::UNIT_CYC_SLOW
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB
	input wire logic [tape_tx_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Panel, tape and line
	input wire tape_tx_pkg::panel_t panel_in,
	input wire logic tape_feed,
	input wire logic line_mark,
	input wire logic line_drive_en,
	input wire logic monitor_mark
);
	logic rate_q;
	int frm_q;
	int unit_q;
	wire logic ctrl_wr = psel && penable && pready && pwrite && paddr == tape_tx_pkg::CTRL_OFF;
	wire logic en_in = panel_in.send_req && panel_in.run && panel_in.tape_present && !panel_in.tape_tight;
	wire logic new_start = frm_q == 0 && !line_mark;
	// ======
	// Frame position tracker
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rate_q <= 1'b0;
			frm_q <= 0;
			unit_q <= UNIT_CYC_FAST;
		end else begin
			if (ctrl_wr)
				rate_q <= pwdata[tape_tx_pkg::CTRL_RATE_BIT];
			if (frm_q != 0)
				frm_q <= (frm_q == 7 * unit_q - 1) ? 0 : frm_q + 1;
			else if (!line_mark)
				frm_q <= 1;
			if (frm_q == 0)
				unit_q <= rate_q ? UNIT_CYC_SLOW : UNIT_CYC_FAST;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	sequence dead_s;
		!en_in [*6];
	endsequence
	apb_wait_a: assert property (setup_s ##1 access_s |=> pready)
		else $error("pready not in second access cycle");
	pready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	mon_copy_a: assert property (monitor_mark == line_mark) else $error("monitor differs from line");
	drive_off_a: assert property (!line_drive_en |-> line_mark) else $error("line spacing while off");
	start_space_a: assert property (frm_q != 0 && frm_q < unit_q |-> !line_mark)
		else $error("start element not spacing");
	stop_mark_a: assert property (frm_q >= 6 * unit_q |-> line_mark) else $error("stop element not marking");
	no_start_a: assert property (dead_s |=> !new_start) else $error("frame began without enable");
	feed_dead_a: assert property (dead_s |=> !tape_feed) else $error("tape fed without enable");
	feed_gap_a: assert property (tape_feed |=> !tape_feed [*4]) else $error("tape feeds too close");
endmodule : tape_tx_sva
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int UF = 10;
	localparam int US = 16;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	tape_tx_pkg::panel_t panel_in = 4'h0;
	logic [4:0] tape_data = 5'h15;
	logic tape_feed;
	logic line_mark;
	logic line_drive_en;
	logic monitor_mark;
	logic [7:0] unit = 8'h0A;
	logic [4:0] rx_char;
	int rx_n;
	int gap;
	logic stop_bad;
	int n_mismatch = 0;
	int n_checks = 0;
	int exp_n = 0;
	logic [2:0] tidx = 3'h0;
	logic [4:0] tape [8] = '{5'h15, 5'h0A, 5'h1F, 5'h00, 5'h01, 5'h10, 5'h13, 5'h0C};
	logic [31:0] rd;
	logic err;
	always #50 ref_clk = ~ref_clk;
	tape_tx #(.UNIT_CYC_FAST(UF), .UNIT_CYC_SLOW(US), .FIFO_DEPTH(16)) u_dut (.ref_clk, .rst, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .panel_in, .tape_data, .tape_feed,
		.line_mark, .line_drive_en, .monitor_mark);
	line_rx u_rx (.clk(ref_clk), .rst, .line_mark, .unit, .rx_char, .rx_n, .gap, .stop_bad);
	// ======
	// Tape reader and order check
	always @(posedge ref_clk) begin
		if (tape_feed === 1'b1) begin
			tidx <= tidx + 3'h1;
			tape_data <= tape[tidx + 3'h1];
		end
	end
	always @(negedge ref_clk) begin
		if (rx_n != exp_n) begin
			chk(rx_char === tape[exp_n % 8], "char order");
			exp_n++;
		end
	end
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic wait_rx(input int n);
		int k = 0;
		n = rx_n + n;
		while (rx_n < n && k < 5000) begin
			@(posedge ref_clk);
			k++;
		end
		if (rx_n < n) begin
			n_mismatch++;
			end_sim();
		end
	endtask : wait_rx
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k = 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			end_sim();
		end
		// Idle edge so the next call never reassigns psel in this step
		@(posedge ref_clk);
	endtask : apb
	// ======
	// Scenarios
	task automatic t_regs();
		apb(1'b0, tape_tx_pkg::CTRL_OFF, 32'h0);
		chk(rd === 32'h0 && err === 1'b0, "ctrl after reset");
		apb(1'b0, 12'h010, 32'h0);
		chk(err === 1'b1 && rd === 32'h0, "unmapped read");
	endtask : t_regs
	task automatic t_key();
		panel_in <= 4'hE;
		for (int m = 0; m < 4; m += 3) begin
			apb(1'b1, tape_tx_pkg::CTRL_OFF, 32'(m));
			cyc(200);
			chk(rx_n === 0 && line_drive_en === 1'b0 && line_mark === 1'b1, "keyboard line");
		end
	endtask : t_key
	task automatic t_run();
		panel_in <= 4'hA;
		apb(1'b1, tape_tx_pkg::CTRL_OFF, 32'h2);
		cyc(200);
		chk(rx_n === 0 && line_mark === 1'b1, "idle without run");
		panel_in <= 4'hE;
		wait_rx(3);
		chk(gap === 7 * UF && stop_bad === 1'b0, "frame length");
		chk(line_drive_en === 1'b1, "line driven");
		apb(1'b0, tape_tx_pkg::STATUS_OFF, 32'h0);
		chk(rd[16:12] >= 5'h0F, "buffer full");
	endtask : t_run
	task automatic t_halt(input logic [3:0] p);
		int n0;
		panel_in <= 4'hE;
		wait_rx(2);
		cyc(20);
		panel_in <= p;
		wait_rx(1);
		n0 = rx_n;
		cyc(300);
		chk(rx_n === n0 && line_mark === 1'b1 && stop_bad === 1'b0, "halt at home");
	endtask : t_halt
	task automatic t_slow();
		apb(1'b0, tape_tx_pkg::COUNT_OFF, 32'h0);
		chk(rd === 32'(rx_n) && err === 1'b0, "count of started chars");
		apb(1'b0, tape_tx_pkg::CHAR_OFF, 32'h0);
		chk(rd === {27'h0, tape[(rx_n - 1) % 8]}, "last char started");
		apb(1'b1, tape_tx_pkg::CTRL_OFF, 32'h5);
		unit <= 8'h10;
		panel_in <= 4'hE;
		wait_rx(3);
		chk(gap === 7 * US && stop_bad === 1'b0, "slow frame length");
	endtask : t_slow
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_key();
		t_run();
		t_halt(4'hA);
		t_halt(4'hF);
		t_halt(4'hC);
		t_halt(4'h6);
		t_slow();
		end_sim();
	end
endmodule : tb
bind tape_tx tape_tx_sva #(.UNIT_CYC_FAST(UNIT_CYC_FAST), .UNIT_CYC_SLOW(UNIT_CYC_SLOW)) u_sva (.ref_clk, .rst,
	.paddr, .psel, .penable, .pwrite, .pwdata, .pready, .panel_in, .tape_feed, .line_mark, .line_drive_en,
	.monitor_mark);
`default_nettype wire
